/* File: ssfp_top.sv */
// serial frame port: 16-bit command slave behind chip select, clock, data in/out
// assumes pins are asynchronous to CLK_SYS_I and the link clock runs well below it
// Summary of operation
// - one command is a 16-bit word shifted in during one select-low frame
// - a frame opens when chip select goes low and stays open while low
// - the word is decoded only after chip select returns high
// - serial out is released to high impedance when chip select goes high
// - serial in is captured on every falling serial clock edge
// - the response shifts one bit after every rising serial clock edge
// - no daisy chain: serial in never reaches serial out
// - only 0 or 16 clocks are legal; else discard and show error first bit
// - serial clock high at either select edge is a frame error; the command is dropped only if high at the select rise
// - bits 6..0 address, bit 7 access type, bits 15..8 data
// - no command is interpreted while the device is in restart
module ssfp_top
	import ssfp_pkg::*;
(
	input  wire logic                 CLK_SYS_I,
	input  wire logic                 RST_B_I,
	input  wire logic                 CHIP_SELECT_N_I,
	input  wire logic                 SCLK_I,
	input  wire logic                 SERIAL_IN_I,
	output logic                      SERIAL_OUT_O,
	output logic                      SERIAL_OUT_OE_O,
	input  wire logic                 RESTART_I,
	input  wire logic [ssfp_pkg::WORD_W-1:0] RSP_DATA_I,
	output logic                      CMD_VALID_O,
	input  wire logic                 CMD_READY_I,
	output logic [ssfp_pkg::ADDR_W-1:0] CMD_ADDR_O,
	output logic                      CMD_ACCESS_O,
	output logic [ssfp_pkg::DATA_W-1:0] CMD_DATA_O
);
	import ssfp_pkg::*;

	typedef struct packed {
		ssfp_state_t       state;
		logic [CNT_W-1:0]  bit_cnt;
		logic [WORD_W-1:0] in_shift;
		logic [WORD_W-1:0] out_shift;
		logic              err;
		logic              rst_seen;
		logic              pend;
		logic [WORD_W-1:0] pend_word;
		logic              sclk_d;
		logic              cs_n_d;
		logic              oe;
	} ssfp_top_st_t;

	ssfp_top_st_t      st_r;
	ssfp_top_st_t      st_nxt;
	logic [SYNC_W-1:0] pins_s;
	logic              cs_n_s;
	logic              sclk_s;
	logic              sdi_s;
	logic              cs_fall;
	logic              cs_rise;
	logic              sclk_fall;
	logic              sclk_rise;
	logic              frame_bad;
	logic [WORD_W-1:0] fifo_word;

	ssfp_word_if #(.W(WORD_W)) word_if ();

	// chip select idles high, clock idles low
	ssfp_sync #(.N(SYNC_W)) u_sync (
		.clk_i     (CLK_SYS_I),
		.rst_b_i   (RST_B_I),
		.rst_val_i (3'h4),
		.d_i       ({CHIP_SELECT_N_I, SCLK_I, SERIAL_IN_I}),
		.q_o       (pins_s)
	);

	assign cs_n_s    = pins_s[2];
	assign sclk_s    = pins_s[1];
	assign sdi_s     = pins_s[0];
	assign cs_fall   = st_r.cs_n_d && !cs_n_s;
	assign cs_rise   = !st_r.cs_n_d && cs_n_s;
	assign sclk_fall = st_r.sclk_d && !sclk_s;
	assign sclk_rise = !st_r.sclk_d && sclk_s;

	// bad count, clock high at release, or restart seen during the frame
	assign frame_bad = ((st_r.bit_cnt != CNT_NONE) && (st_r.bit_cnt != CNT_FULL))
		|| sclk_s
		|| st_r.rst_seen || RESTART_I;

	always_comb begin
		st_nxt = st_r;
		st_nxt.sclk_d = sclk_s;
		st_nxt.cs_n_d = cs_n_s;
		if (st_r.pend && word_if.ready) begin
			st_nxt.pend = 1'b0;
		end
		case (st_r.state)
			SSFP_IDLE: begin
				if (cs_fall) begin
					st_nxt.state = SSFP_FRAME;
					st_nxt.bit_cnt = CNT_NONE;
					st_nxt.rst_seen = RESTART_I;
					st_nxt.oe = 1'b1;
					// error is reported once, in the first bit of this frame
					st_nxt.out_shift = {st_r.err, RSP_DATA_I[ERR_BIT-1:0]};
					st_nxt.err = sclk_s;
				end
			end
			SSFP_FRAME: begin
				if (sclk_fall) begin
					st_nxt.in_shift = {st_r.in_shift[WORD_W-2:0], sdi_s};
					if (st_r.bit_cnt != CNT_SAT) begin
						st_nxt.bit_cnt = st_r.bit_cnt + CNT_W'(1);
					end
				end
				if (sclk_rise) begin
					st_nxt.out_shift = {st_r.out_shift[WORD_W-2:0], 1'b0};
				end
				if (RESTART_I) begin
					st_nxt.rst_seen = 1'b1;
				end
				if (cs_rise) begin
					st_nxt.state = SSFP_IDLE;
					st_nxt.oe = 1'b0;
					if (frame_bad) begin
						st_nxt.err = 1'b1;
					end else if (st_r.bit_cnt == CNT_FULL) begin
						// queue still blocked: drop the word and flag it
						if (st_nxt.pend) begin
							st_nxt.err = 1'b1;
						end else begin
							st_nxt.pend = 1'b1;
							st_nxt.pend_word = st_r.in_shift;
						end
					end
				end
			end
			default: begin
				st_nxt.state = SSFP_IDLE;
				st_nxt.oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_r <= '{state: SSFP_IDLE, bit_cnt: CNT_NONE, in_shift: WORD_RST,
				out_shift: WORD_RST, err: 1'b0, rst_seen: 1'b0, pend: 1'b0,
				pend_word: WORD_RST, sclk_d: 1'b0, cs_n_d: 1'b1, oe: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign word_if.valid = st_r.pend;
	assign word_if.data  = st_r.pend_word;

	ssfp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i       (CLK_SYS_I),
		.rst_b_i     (RST_B_I),
		.in_if       (word_if),
		.out_valid_o (CMD_VALID_O),
		.out_ready_i (CMD_READY_I),
		.out_data_o  (fifo_word)
	);

	assign CMD_ADDR_O      = fifo_word[ADDR_LSB +: ADDR_W];
	assign CMD_ACCESS_O    = fifo_word[ACC_BIT];
	assign CMD_DATA_O      = fifo_word[DATA_LSB +: DATA_W];
	assign SERIAL_OUT_O    = st_r.out_shift[ERR_BIT];
	assign SERIAL_OUT_OE_O = st_r.oe;

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_B_I);

	property p_release_out;
		(st_r.state == SSFP_FRAME) && cs_rise |=> !SERIAL_OUT_OE_O;
	endproperty
	a_release_out: assert property (p_release_out) else $error("out not released");

	property p_drive_in_frame;
		(st_r.state == SSFP_IDLE) && cs_fall |=> SERIAL_OUT_OE_O throughout
			(st_r.state == SSFP_FRAME) [*1];
	endproperty
	a_drive_in_frame: assert property (p_drive_in_frame) else $error("frame not opened");

	property p_decode_at_release;
		$rose(st_r.pend) |-> $past(cs_rise) && $past(st_r.bit_cnt) == CNT_FULL;
	endproperty
	a_decode_at_release: assert property (p_decode_at_release) else $error("early decode");

	property p_bad_count;
		(st_r.state == SSFP_FRAME) && cs_rise && (st_r.bit_cnt != CNT_NONE)
			&& (st_r.bit_cnt != CNT_FULL) |=> st_r.err && !$rose(st_r.pend);
	endproperty
	a_bad_count: assert property (p_bad_count) else $error("bad count not flagged");

	property p_clk_high_edge;
		(cs_fall && (st_r.state == SSFP_IDLE) || cs_rise && (st_r.state == SSFP_FRAME))
			&& sclk_s |=> st_r.err;
	endproperty
	a_clk_high_edge: assert property (p_clk_high_edge) else $error("clock high not flagged");

	property p_restart_ignored;
		(st_r.state == SSFP_FRAME) && cs_rise && RESTART_I |=> !$rose(st_r.pend) ##0 st_r.err;
	endproperty
	a_restart_ignored: assert property (p_restart_ignored) else $error("restart frame used");

	property p_capture_fall;
		(st_r.state == SSFP_FRAME) && sclk_fall |=> st_r.in_shift[0] == $past(sdi_s)
			&& st_r.in_shift[WORD_W-1:1] == $past(st_r.in_shift[WORD_W-2:0]);
	endproperty
	a_capture_fall: assert property (p_capture_fall) else $error("input not captured");

	property p_shift_rise;
		(st_r.state == SSFP_FRAME) && sclk_rise && !cs_rise |=>
			SERIAL_OUT_O == $past(st_r.out_shift[ERR_BIT-1]);
	endproperty
	a_shift_rise: assert property (p_shift_rise) else $error("output not shifted");

	property p_err_first_bit;
		(st_r.state == SSFP_IDLE) && cs_fall |=> SERIAL_OUT_O == $past(st_r.err)
			##1 !st_r.err || $past(sclk_s, 2);
	endproperty
	a_err_first_bit: assert property (p_err_first_bit) else $error("error bit missing");

	property p_out_steady;
		(st_r.state == SSFP_FRAME) && !sclk_rise && !cs_rise |=> $stable(SERIAL_OUT_O);
	endproperty
	a_out_steady: assert property (p_out_steady) else $error("output moved");

	property p_count_limit;
		st_r.bit_cnt <= CNT_SAT;
	endproperty
	a_count_limit: assert property (p_count_limit) else $error("count past limit");

	property p_count_clear;
		(st_r.state == SSFP_IDLE) && cs_fall |=> st_r.bit_cnt == CNT_NONE;
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("count not cleared");

	property p_count_step;
		(st_r.state == SSFP_FRAME) && sclk_fall && (st_r.bit_cnt != CNT_SAT) |=>
			st_r.bit_cnt == $past(st_r.bit_cnt) + CNT_W'(1);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count not stepped");

	property p_idle_hold;
		(st_r.state == SSFP_IDLE) && !cs_fall |=> $stable(st_r.in_shift);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("shift outside frame");

	property p_idle_off;
		(st_r.state == SSFP_IDLE) && !cs_fall |=> !SERIAL_OUT_OE_O;
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("driven outside frame");

	property p_no_early;
		(st_r.state == SSFP_FRAME) && !cs_rise |=> !$rose(st_r.pend);
	endproperty
	a_no_early: assert property (p_no_early) else $error("decode inside frame");

	property p_load_rsp;
		(st_r.state == SSFP_IDLE) && cs_fall |=>
			st_r.out_shift[ERR_BIT-1:0] == $past(RSP_DATA_I[ERR_BIT-1:0]);
	endproperty
	a_load_rsp: assert property (p_load_rsp) else $error("response not loaded");

	property p_word_taken;
		$rose(st_r.pend) |-> st_r.pend_word == $past(st_r.in_shift);
	endproperty
	a_word_taken: assert property (p_word_taken) else $error("word not taken");

	property p_restart_seen;
		(st_r.state == SSFP_FRAME) && RESTART_I |=> st_r.rst_seen;
	endproperty
	a_restart_seen: assert property (p_restart_seen) else $error("restart missed");

	property p_head_stands;
		CMD_VALID_O && !CMD_READY_I |=> CMD_VALID_O && $stable(fifo_word);
	endproperty
	a_head_stands: assert property (p_head_stands) else $error("head moved");

	property p_drop_blocked;
		(st_r.state == SSFP_FRAME) && cs_rise && !frame_bad && (st_r.bit_cnt == CNT_FULL)
			&& st_r.pend && !word_if.ready |=> st_r.err && !$rose(st_r.pend);
	endproperty
	a_drop_blocked: assert property (p_drop_blocked) else $error("blocked word kept");

	property p_word_queued;
		(st_r.state == SSFP_FRAME) && cs_rise && !frame_bad && (st_r.bit_cnt == CNT_FULL)
			&& !st_r.pend |=> st_r.pend;
	endproperty
	a_word_queued: assert property (p_word_queued) else $error("good word lost");

	c_good_frame: cover property ((st_r.state == SSFP_FRAME) && cs_rise && !frame_bad
		&& st_r.bit_cnt == CNT_FULL);
	c_zero_clock: cover property ((st_r.state == SSFP_FRAME) && cs_rise
		&& st_r.bit_cnt == CNT_NONE);
	c_error_frame: cover property ((st_r.state == SSFP_FRAME) && cs_rise && frame_bad);
	c_queue_full: cover property (st_r.pend && !word_if.ready);
	c_restart_frame: cover property ((st_r.state == SSFP_FRAME) && cs_rise
		&& st_r.rst_seen);
endmodule

/* File: ssfp_pkg.sv */
// constants and types shared by the serial frame port files
// assumes a single system clock domain; pins are synchronised before use
package ssfp_pkg;
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned CNT_W      = 5;
	localparam logic [4:0]  CNT_FULL   = 5'h10;
	localparam logic [4:0]  CNT_SAT    = 5'h11;
	localparam logic [4:0]  CNT_NONE   = 5'h00;
	localparam int unsigned ADDR_LSB   = 0;
	localparam int unsigned ADDR_W     = 7;
	localparam int unsigned ACC_BIT    = 7;
	localparam int unsigned DATA_LSB   = 8;
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned ERR_BIT    = 15;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam logic [15:0] WORD_RST   = 16'h0000;
	localparam int unsigned SYNC_W     = 3;

	typedef enum logic [0:0] {
		SSFP_IDLE  = 1'b0,
		SSFP_FRAME = 1'b1
	} ssfp_state_t;
endpackage

/* File: ssfp_word_if.sv */
// word carrier between the frame port and its output queue
// assumes both ends run on the system clock
interface ssfp_word_if #(parameter int unsigned W = 16);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* File: ssfp_sync.sv */
// two-flop synchroniser for a group of asynchronous pins
// assumes nothing reads the first stage except the second
module ssfp_sync #(
	parameter int unsigned N = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [N-1:0] rst_val_i,
	input  wire logic [N-1:0] d_i,
	output logic      [N-1:0] q_o
);
	typedef struct packed {
		logic [N-1:0] meta;
		logic [N-1:0] stab;
	} ssfp_sync_st_t;

	ssfp_sync_st_t st_r;
	ssfp_sync_st_t st_nxt;
	logic          seeded_r;

	always_comb begin
		st_nxt = st_r;
		st_nxt.meta = d_i;
		st_nxt.stab = st_r.meta;
	end

	// constant under reset; both stages take the idle level on the first clock after release
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
			seeded_r <= 1'b0;
		end else begin
			seeded_r <= 1'b1;
			if (seeded_r) begin
				st_r <= st_nxt;
			end else begin
				st_r <= '{meta: rst_val_i, stab: rst_val_i};
			end
		end
	end

	// idle level shown until seeded, so no false edge follows reset
	assign q_o = seeded_r ? st_r.stab : rst_val_i;
endmodule

/* File: ssfp_fifo.sv */
// small word queue with valid/ready on both sides
// assumes fill and drain share the system clock
module ssfp_fifo #(
	parameter int unsigned W     = 16,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	ssfp_word_if.snk          in_if,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	localparam int unsigned PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wr;
		logic [PW-1:0]           rd;
		logic [PW:0]             cnt;
	} ssfp_fifo_st_t;

	ssfp_fifo_st_t st_r;
	ssfp_fifo_st_t st_nxt;
	logic          push;
	logic          pop;

	assign in_if.ready = (st_r.cnt != (PW+1)'(DEPTH));
	assign out_valid_o = (st_r.cnt != '0);
	assign out_data_o  = st_r.mem[st_r.rd];
	assign push        = in_if.valid && in_if.ready;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wr] = in_if.data;
			st_nxt.wr = (st_r.wr == PW'(DEPTH - 1)) ? '0 : st_r.wr + PW'(1);
		end
		if (pop) begin
			st_nxt.rd = (st_r.rd == PW'(DEPTH - 1)) ? '0 : st_r.rd + PW'(1);
		end
		st_nxt.cnt = st_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

/* File: ssfp_master_model.sv */
// serial master model: drives select, clock and data in, samples data out
// assumes so_i already resolved to z while the port does not drive it
module ssfp_master_model (
	input  wire logic clk_i,
	input  wire logic so_i,
	input  wire logic oe_i,
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      sdi_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o  = 1'b0;
	end

	// hi holds the clock high across the select fall, and with n of 0 across the select rise too, on purpose
	task automatic frame(input int n, input logic [15:0] w, input logic hi,
		output logic [15:0] rsp, output logic on, output logic off);
		rsp = 16'hxxxx;
		@(posedge clk_i);
		#1;
		sclk_o = hi;
		repeat (8) @(posedge clk_i);
		#1;
		cs_n_o = 1'b0;
		repeat (8) @(posedge clk_i);
		#1;
		on = oe_i;
		rsp[15] = so_i;
		for (int i = 0; i < n; i++) begin
			// data moves on the rise so it is settled at the sampling fall
			#80 sclk_o = 1'b1;
			sdi_o = (i < 16) ? w[15-i] : ~sdi_o;
			#80 sclk_o = 1'b0;
			if (i < 15) begin
				rsp[14-i] = so_i;
			end
		end
		#80 cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		repeat (8) @(posedge clk_i);
		#1;
		off = oe_i;
		sclk_o = 1'b0;
	endtask
endmodule

/* File: ssfp_top_tb.sv */
// self-checking bench for the serial frame port
// assumes the master model file and all design files are compiled first
module ssfp_top_tb;
	import ssfp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        restart = 1'b0;
	logic [15:0] rsp_data = 16'h0000;
	logic        cmd_ready = 1'b0;
	logic        stall = 1'b0;
	logic        err_exp = 1'b0;
	logic        cs_n, sclk, serial_in, so, oe, cmd_valid, acc;
	logic [6:0]  addr;
	logic [7:0]  data;
	wire         so_bus;
	logic [15:0] exp_q[$];
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          cyc = 0;

	assign so_bus = oe ? so : 1'bz;

	ssfp_master_model m (.clk_i(clk), .so_i(so_bus), .oe_i(oe), .cs_n_o(cs_n),
		.sclk_o(sclk), .sdi_o(serial_in));

	ssfp_top dut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .CHIP_SELECT_N_I(cs_n), .SCLK_I(sclk),
		.SERIAL_IN_I(serial_in), .SERIAL_OUT_O(so), .SERIAL_OUT_OE_O(oe), .RESTART_I(restart),
		.RSP_DATA_I(rsp_data), .CMD_VALID_O(cmd_valid), .CMD_READY_I(cmd_ready),
		.CMD_ADDR_O(addr), .CMD_ACCESS_O(acc), .CMD_DATA_O(data));

	always #5 clk = ~clk;

	task automatic test_done;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cmp_rsp(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (e !== g) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmp_cmd(input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (e !== g) begin
			n_mismatch++;
			$display("unexpected command word: expected %h seen %h", e, g);
		end
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end

	// consumer takes words at random, or never while stalled
	always @(posedge clk) begin
		#1;
		cmd_ready = stall ? 1'b0 : 1'($urandom);
	end

	// looks at the head while it stands, before the edge that pops it
	always @(negedge clk) begin
		if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
			cmp_cmd(exp_q.size() ? exp_q.pop_front() : 16'hxxxx, {data, acc, addr});
	end

	task automatic run(input int n, input logic hi, input logic rs, input logic drop);
		logic [15:0] w, r, got;
		logic        on, off, kept;
		w = 16'($urandom);
		r = 16'($urandom);
		kept = (n == 16) && !hi && !rs && !drop;
		@(posedge clk);
		#1;
		rsp_data = r;
		restart = rs;
		if (kept)
			exp_q.push_back(w);
		m.frame(n, w, hi, got, on, off);
		restart = 1'b0;
		cmp_rsp("drive enable", 16'h0001, {15'h0000, on});
		cmp_rsp("release", 16'h0000, {15'h0000, off});
		if (!hi && !rs)
			cmp_rsp("error bit", {15'h0000, err_exp}, {15'h0000, got[15]});
		if (!hi && !rs && n == 16)
			cmp_rsp("response", {1'b0, r[14:0]}, {1'b0, got[14:0]});
		err_exp = !kept && (n != 0 || hi || rs);
	endtask

	task automatic drain;
		for (int i = 0; i < 400 && exp_q.size() != 0; i++)
			@(posedge clk);
		cmp_rsp("queue left", 16'h0000, 16'(exp_q.size()));
	endtask

	initial begin
		int bad_n[4] = '{1, 15, 17, 0};
		void'($urandom(53));
		repeat (8) @(posedge clk);
		#1;
		rst_b = 1'b1;
		repeat (6) @(posedge clk);
		repeat (4) run(16, 1'b0, 1'b0, 1'b0);
		drain();
		$display("test words done");
		foreach (bad_n[k]) begin
			run(bad_n[k], 1'b0, 1'b0, 1'b0);
			run(0, 1'b0, 1'b0, 1'b0);
		end
		$display("test counts done");
		run(0, 1'b1, 1'b0, 1'b0);
		run(0, 1'b0, 1'b0, 1'b0);
		$display("test clock high done");
		run(16, 1'b0, 1'b1, 1'b0);
		run(16, 1'b0, 1'b0, 1'b0);
		run(0, 1'b0, 1'b0, 1'b0);
		drain();
		$display("test restart done");
		stall = 1'b1;
		repeat (5) run(16, 1'b0, 1'b0, 1'b0);
		run(16, 1'b0, 1'b0, 1'b1);
		run(0, 1'b0, 1'b0, 1'b0);
		stall = 1'b0;
		drain();
		$display("test queue full done");
		test_done();
	end
endmodule
